// File: include/lrcd_map.vh
/*
 * Constants of the relay command decoder: identifiers, field positions,
 * error codes, status codes and frame lengths.
 * Assumes a LIN frame layer that hands over header and byte strobes.
 */
// Overview of operation
// - An output control frame has eight data bytes of four 2-bit commands.
// - Command 01 turns a channel off, 10 turns it on, 00 and 11 keep it.
// - Position A..D takes byte pair 1-2..7-8, first byte channels 1-4.
// - Open-load diagnostics of channels 4 and 8 run while they are off, one cycle late.
// - Output control identifier is address index times 8 plus 1.
// - Get status answer is eight bytes, bytes 4-8 zero, enhanced checksum.
// - Byte 1 bits 7:5 carry the highest pending bus error code.
// - Sending a response with the error code clears it to no error.
// - Channel status: 00 open load, 01 off, 10 on, 11 latched off.
// - Channels 4 and 8 report open load and local thermal; all report OC.
// - Fault field reads 00000, 00100 or 01000 only.
// - Get status identifier is address index times 8 plus 2 plus position.
// - Global thermal ranks first; latched faults clear on an off command.
// - Protected identifier adds even parity P0 and odd parity P1.
`ifndef LRCD_MAP_VH
`define LRCD_MAP_VH
`define LRCD_ID_CTRL_OFS 3'h1
`define LRCD_ID_STAT_OFS 3'h2
`define LRCD_NAD_LAST 3'h6
`define LRCD_DATA_LAST 4'h7
`define LRCD_CSUM_IDX 4'h8
`define LRCD_CSUM_OK 8'hFF
`define LRCD_CMD_OFF 2'h1
`define LRCD_CMD_ON 2'h2
`define LRCD_ST_OPEN 2'h0
`define LRCD_ST_OFF 2'h1
`define LRCD_ST_ON 2'h2
`define LRCD_ST_LATCH 2'h3
`define LRCD_ERR_NONE 3'h0
`define LRCD_ERR_RESET 3'h1
`define LRCD_ERR_DATA 3'h4
`define LRCD_ERR_CSUM 3'h5
`define LRCD_ERR_FRAME 3'h6
`define LRCD_ERR_PARITY 3'h7
`define LRCD_APP_NONE 5'h00
`define LRCD_APP_GTSD 5'h04
`define LRCD_APP_CH48 5'h08
`define LRCD_ZERO_BYTE 8'h00
`define LRCD_CH4 3
`define LRCD_CH8 7
`endif

// File: rtl/lrcd_csum_add.v
/*
 * Enhanced checksum step: adds one byte with end-around carry.
 * Assumes the caller holds the running sum in a register.
 */
`timescale 1ns/1ps
module lrcd_csum_add (
	input wire [7:0] i_acc, // running sum
	input wire [7:0] i_byte, // byte to add
	output wire [7:0] o_sum // sum with carry folded back
);
	wire [8:0] raw;
	assign raw = {1'b0, i_acc} + {1'b0, i_byte};
	assign o_sum = raw[7:0] + {7'h00, raw[8]};
endmodule // lrcd_csum_add

// File: rtl/lrcd_decoder.v
/*
 * Application layer of the eight-channel relay driver: decodes output
 * control frames and answers get status requests.
 * Assumes a frame layer on the same clock that strobes headers and bytes
 * and takes response bytes on a valid/ready handshake.
 */
`timescale 1ns/1ps
`include "lrcd_map.vh"
module lrcd_decoder (
	input wire i_core_clk, // 250 MHz core clock
	input wire i_reset, // synchronous reset, active high
	input wire [2:0] i_nad_sel, // address index 0..6, pin strap
	input wire [1:0] i_position_select, // position A..D, pin strap
	input wire i_hdr_valid, // header received, pulse
	input wire [7:0] i_pid, // protected identifier with i_hdr_valid
	input wire i_rx_valid, // data byte received, pulse
	input wire [7:0] i_rx_byte, // data byte with i_rx_valid
	input wire i_err_data, // data error event, pulse
	input wire i_err_framing, // byte framing error event, pulse
	input wire i_err_parity, // identifier parity error event, pulse
	input wire i_tx_ready, // frame layer takes o_tx_byte
	input wire [7:0] i_overcurrent, // overcurrent per channel, pin
	input wire [1:0] i_thermal_shutdown, // local thermal, ch 4 and 8, pin
	input wire i_global_tsd, // global thermal shutdown, pin
	input wire [1:0] i_open_load_fault, // open load, ch 4 and 8, pin
	output reg [7:0] o_channel_output, // drive on per channel
	output reg [1:0] o_open_load_en, // open-load check, ch 4 and 8
	output reg o_tx_valid, // response byte valid
	output reg [7:0] o_tx_byte, // response byte
	output reg [2:0] o_bus_error_code, // stored bus error code
	output reg [4:0] o_app_fault_info // application fault field
);
	localparam S_IDLE = 2'h0;
	localparam S_RX = 2'h1;
	localparam S_TX = 2'h2;

	////////////////////////////////////////////////////////////////////
	// identifier with parity
	function [7:0] pid_of;
		input [5:0] id;
		begin
			pid_of = {~(id[1] ^ id[3] ^ id[4] ^ id[5]),
				id[0] ^ id[1] ^ id[2] ^ id[4], id};
		end
	endfunction

	function [2:0] err_max;
		input [2:0] a;
		input [2:0] b;
		begin
			err_max = (a > b) ? a : b;
		end
	endfunction

	// two-bit status of one channel, latch ranks over drive and open load
	function [1:0] status_of;
		input latched;
		input drive;
		input open_load;
		begin
			if (latched) begin
				status_of = `LRCD_ST_LATCH;
			end else if (drive) begin
				status_of = `LRCD_ST_ON;
			end else if (open_load) begin
				status_of = `LRCD_ST_OPEN;
			end else begin
				status_of = `LRCD_ST_OFF;
			end
		end
	endfunction

	////////////////////////////////////////////////////////////////////
	// pin synchronisers
	// straps and fault pins come from outside: two flops before any use
	reg [17:0] sync1_r;
	reg [17:0] sync2_r;
	always @(posedge i_core_clk) begin
		if (i_reset) begin
			sync1_r <= 18'h00000;
			sync2_r <= 18'h00000;
		end else begin
			sync1_r <= {i_nad_sel, i_position_select, i_overcurrent,
				i_thermal_shutdown, i_global_tsd, i_open_load_fault};
			sync2_r <= sync1_r;
		end
	end
	wire [2:0] nad = sync2_r[17:15];
	wire [1:0] pos = sync2_r[14:13];
	wire [7:0] oc = sync2_r[12:5];
	wire [1:0] ltsd = sync2_r[4:3];
	wire gtsd = sync2_r[2];
	wire [1:0] olf = sync2_r[1:0];

	wire nad_ok = (nad <= `LRCD_NAD_LAST);
	wire [7:0] ctrl_pid = pid_of({nad, `LRCD_ID_CTRL_OFS});
	wire [7:0] stat_pid = pid_of({nad, `LRCD_ID_STAT_OFS} +
		{4'h0, pos});
	// index 7 is no node: neither header can match then
	wire hit_ctrl = i_hdr_valid & nad_ok & (i_pid == ctrl_pid);
	wire hit_stat = i_hdr_valid & nad_ok & (i_pid == stat_pid);

	////////////////////////////////////////////////////////////////////
	// frame sequencer
	reg [1:0] state_r;
	reg [3:0] idx_r;
	reg [7:0] acc_r;
	reg [15:0] cmd_r;
	reg [15:0] snap_r;
	reg apply_r;
	reg csum_bad_r;
	reg err_clr;
	wire [7:0] rx_sum;
	wire [7:0] tx_sum;
	wire [15:0] ch_status;
	wire [2:0] pair_lo = {pos, 1'b0};
	wire tx_take = (state_r == S_TX) & o_tx_valid & i_tx_ready;

	lrcd_csum_add u_rx_sum (
		.i_acc(acc_r),
		.i_byte(i_rx_byte),
		.o_sum(rx_sum)
	);
	lrcd_csum_add u_tx_sum (
		.i_acc(acc_r),
		.i_byte(o_tx_byte),
		.o_sum(tx_sum)
	);

	// next response byte after index idx_r
	reg [7:0] tx_next;
	always @* begin
		case (idx_r)
		4'h0: tx_next = snap_r[7:0];
		4'h1: tx_next = snap_r[15:8];
		4'h7: tx_next = ~tx_sum;
		default: tx_next = `LRCD_ZERO_BYTE;
		endcase
	end

	always @(posedge i_core_clk) begin
		if (i_reset) begin
			state_r <= S_IDLE;
			idx_r <= 4'h0;
			acc_r <= `LRCD_ZERO_BYTE;
			cmd_r <= 16'h0000;
			snap_r <= 16'h0000;
			apply_r <= 1'b0;
			csum_bad_r <= 1'b0;
			o_tx_valid <= 1'b0;
			o_tx_byte <= `LRCD_ZERO_BYTE;
		end else begin
			apply_r <= 1'b0;
			csum_bad_r <= 1'b0;
			// any header ends the frame or response in flight
			if (hit_ctrl) begin
				state_r <= S_RX;
				idx_r <= 4'h0;
				acc_r <= i_pid;
				o_tx_valid <= 1'b0;
			end else if (hit_stat) begin
				state_r <= S_TX;
				idx_r <= 4'h0;
				acc_r <= i_pid;
				snap_r <= ch_status;
				o_tx_valid <= 1'b1;
				o_tx_byte <= {o_bus_error_code, o_app_fault_info};
			end else if (i_hdr_valid) begin
				state_r <= S_IDLE;
				o_tx_valid <= 1'b0;
			end else begin
				case (state_r)
				S_RX: begin
					if (i_rx_valid) begin
						idx_r <= idx_r + 4'h1;
						acc_r <= rx_sum;
						if (idx_r == {1'b0, pair_lo}) begin
							cmd_r[7:0] <= i_rx_byte;
						end
						if (idx_r == {1'b0, pair_lo} + 4'h1) begin
							cmd_r[15:8] <= i_rx_byte;
						end
						// ninth byte is the checksum; apply waits a cycle
						if (idx_r == `LRCD_CSUM_IDX) begin
							state_r <= S_IDLE;
							apply_r <= (rx_sum == `LRCD_CSUM_OK);
							csum_bad_r <= (rx_sum != `LRCD_CSUM_OK);
						end
					end
				end
				S_TX: begin
					if (tx_take) begin
						idx_r <= idx_r + 4'h1;
						acc_r <= tx_sum;
						o_tx_byte <= tx_next;
						if (idx_r == `LRCD_CSUM_IDX) begin
							state_r <= S_IDLE;
							o_tx_valid <= 1'b0;
						end
					end
				end
				S_IDLE: begin
					idx_r <= 4'h0;
				end
				default: begin
					state_r <= S_IDLE;
					o_tx_valid <= 1'b0;
				end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// bus error code, cleared by sending it, the higher code wins
	wire [2:0] err_ev;
	assign err_ev = err_max(err_max(
		i_err_parity ? `LRCD_ERR_PARITY : `LRCD_ERR_NONE,
		i_err_framing ? `LRCD_ERR_FRAME : `LRCD_ERR_NONE),
		err_max(csum_bad_r ? `LRCD_ERR_CSUM : `LRCD_ERR_NONE,
		i_err_data ? `LRCD_ERR_DATA : `LRCD_ERR_NONE));
	// byte 1 leaving carries the code, so that hand-over clears it
	always @* begin
		err_clr = tx_take & (idx_r == 4'h0);
	end
	always @(posedge i_core_clk) begin
		if (i_reset) begin
			o_bus_error_code <= `LRCD_ERR_RESET;
		end else begin
			o_bus_error_code <= err_max(err_clr ? `LRCD_ERR_NONE :
				o_bus_error_code, err_ev);
		end
	end

	////////////////////////////////////////////////////////////////////
	// channels
	reg [7:0] latched_r;
	wire [7:0] off_seen;
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_ch
			localparam IS48 = (gi == `LRCD_CH4) || (gi == `LRCD_CH8);
			wire [1:0] cmd = cmd_r[2*gi+1:2*gi];
			wire cmd_off = apply_r & (cmd == `LRCD_CMD_OFF);
			wire cmd_on = apply_r & (cmd == `LRCD_CMD_ON);
			wire fault = oc[gi] | (IS48 & ltsd[gi/4]);
			wire ol = IS48 & olf[gi/4] & o_open_load_en[gi/4];
			assign off_seen[gi] = cmd_off;
			// a fault in the cycle of an off command still latches
			always @(posedge i_core_clk) begin
				if (i_reset) begin
					o_channel_output[gi] <= 1'b0;
					latched_r[gi] <= 1'b0;
				end else if (o_channel_output[gi] & fault) begin
					o_channel_output[gi] <= 1'b0;
					latched_r[gi] <= 1'b1;
				end else if (cmd_off) begin
					o_channel_output[gi] <= 1'b0;
					latched_r[gi] <= 1'b0;
				end else if (gtsd) begin
					o_channel_output[gi] <= 1'b0;
				end else if (cmd_on & ~latched_r[gi]) begin
					o_channel_output[gi] <= 1'b1;
				end
			end
			assign ch_status[2*gi+1:2*gi] = status_of(latched_r[gi],
				o_channel_output[gi], ol);
		end
	endgenerate

	always @(posedge i_core_clk) begin
		if (i_reset) begin
			o_open_load_en <= 2'h3;
		end else begin
			// checks follow the drive one cycle late
			o_open_load_en <= {~o_channel_output[`LRCD_CH8],
				~o_channel_output[`LRCD_CH4]};
		end
	end

	////////////////////////////////////////////////////////////////////
	// application fault field
	reg gtsd_seen_r;
	always @(posedge i_core_clk) begin
		if (i_reset) begin
			gtsd_seen_r <= 1'b0;
			o_app_fault_info <= `LRCD_APP_NONE;
		end else begin
			if (gtsd) begin
				gtsd_seen_r <= 1'b1;
			end else if (|off_seen) begin
				gtsd_seen_r <= 1'b0;
			end
			// global thermal holds the field until an off command
			if (gtsd | gtsd_seen_r) begin
				o_app_fault_info <= `LRCD_APP_GTSD;
			end else if (latched_r[`LRCD_CH4] | latched_r[`LRCD_CH8]) begin
				o_app_fault_info <= `LRCD_APP_CH48;
			end else begin
				o_app_fault_info <= `LRCD_APP_NONE;
			end
		end
	end
endmodule // lrcd_decoder

// File: tb/lrcd_decoder_props.sv
/* port assertions of the relay command decoder
   assumes a bind from the bench, one clock domain */
`timescale 1ns/1ps
module lrcd_decoder_props (
	input wire i_core_clk, // core clock
	input wire i_reset, // sync reset
	input wire i_hdr_valid, // header strobe
	input wire i_err_data, // data error event
	input wire i_err_framing, // framing event
	input wire i_err_parity, // parity event
	input wire i_tx_ready, // response taken
	input wire i_global_tsd, // global thermal
	input wire [7:0] o_channel_output, // drive on
	input wire [1:0] o_open_load_en, // ol check enable
	input wire o_tx_valid, // response valid
	input wire [7:0] o_tx_byte, // response byte
	input wire [2:0] o_bus_error_code, // error code
	input wire [4:0] o_app_fault_info // fault field
);
default clocking @(posedge i_core_clk); endclocking
default disable iff (i_reset);
////////////////////////////////////////////////////////////////////////
chk_reset_code: assert property (
	$fell(i_reset) |-> o_bus_error_code == 3'h1) else $error("no reset code");
chk_err_parity: assert property (
	i_err_parity |=> o_bus_error_code == 3'h7) else $error("parity code");
chk_err_frame: assert property (
	i_err_framing |=> o_bus_error_code[2:1] == 2'h3) else $error("frame code");
chk_err_data: assert property (
	i_err_data |=> o_bus_error_code[2]) else $error("data code");
chk_app_legal: assert property (
	o_app_fault_info inside {5'h00, 5'h04, 5'h08}) else $error("bad fault");
chk_tx_hold: assert property (
	o_tx_valid && !i_tx_ready && !i_hdr_valid |=>
	o_tx_valid && $stable(o_tx_byte))
	else $error("response byte moved");
chk_gtsd_off: assert property (
	i_global_tsd [*4] |=> o_channel_output == 8'h00)
	else $error("on during global thermal");
chk_ol_off_only: assert property (
	o_channel_output[3] && $past(o_channel_output[3]) |-> !o_open_load_en[0])
	else $error("open load check while on");
cover property (o_tx_valid && i_tx_ready);
cover property (o_bus_error_code == 3'h5);
cover property (o_app_fault_info == 5'h08);
endmodule // lrcd_decoder_props

// File: tb/lrcd_lin_master.sv
/* bus master model: sends headers and frames, collects responses
   assumes the decoder on the same clock */
`timescale 1ns/1ps
module lrcd_lin_master (
	input wire i_clk, // core clock
	input wire i_tx_valid, // response valid
	input wire [7:0] i_tx_byte, // response byte
	output reg o_hdr_valid = 1'b0, // header strobe
	output reg [7:0] o_pid = 8'h00, // protected id
	output reg o_rx_valid = 1'b0, // byte strobe
	output reg [7:0] o_rx_byte = 8'h00, // data byte
	output reg o_tx_ready = 1'b0 // takes response byte
);
function [7:0] pid(input [5:0] id);
	pid = {~^{id[1], id[3], id[4], id[5]}, ^{id[0], id[1], id[2], id[4]}, id};
endfunction
function [7:0] add(input [7:0] a, input [7:0] b);
	reg [8:0] t;
	begin
		t = a + b;
		add = t[7:0] + t[8];
	end
endfunction
task send(input [7:0] p, input [63:0] d, input bad);
	reg [7:0] s;
	integer k;
	begin
		@(posedge i_clk) #1;
		o_hdr_valid = 1'b1;
		o_pid = p;
		s = p;
		for (k = 0; k < 9; k = k + 1) begin
			@(posedge i_clk) #1;
			o_hdr_valid = 1'b0;
			o_pid = ~o_pid;
			o_rx_valid = 1'b1;
			o_rx_byte = k < 8 ? d[63 - 8 * k -: 8] : (bad ? s : ~s);
			s = add(s, o_rx_byte);
		end
		@(posedge i_clk) #1;
		o_rx_valid = 1'b0;
		o_rx_byte = ~o_rx_byte;
	end
endtask
// ready toggles every cycle so the answer is also taken slowly
task status(input [7:0] p, output [71:0] r);
	integer k, n;
	reg hit;
	reg [7:0] b;
	begin
		@(posedge i_clk) #1;
		o_hdr_valid = 1'b1;
		o_pid = p;
		k = 0;
		n = 0;
		r = 72'h0;
		while (k < 9 && n < 60) begin
			// settled values that the next rising edge takes
			@(negedge i_clk);
			hit = i_tx_valid === 1'b1 && o_tx_ready;
			b = i_tx_byte;
			@(posedge i_clk) #1;
			if (hit) begin
				r = {r[63:0], b};
				k = k + 1;
			end
			o_hdr_valid = 1'b0;
			o_pid = ~o_pid;
			o_tx_ready = ~o_tx_ready && k < 9;
			n = n + 1;
		end
	end
endtask
endmodule // lrcd_lin_master

// File: tb/lrcd_decoder_tb.sv
/* self-checking bench of the relay command decoder
   assumes the master model and the checker beside it */
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin \
	miscompares++; $display("unexpected %s exp %h got %h", nm, e, s); end end
module lrcd_decoder_tb;
reg i_core_clk = 0, i_reset = 1, i_global_tsd = 0;
reg i_err_data = 0, i_err_framing = 0, i_err_parity = 0;
reg [2:0] i_nad_sel = 3'h0;
reg [1:0] i_position_select = 2'h1;
reg [7:0] i_overcurrent = 8'h00;
reg [1:0] i_thermal_shutdown = 2'h0, i_open_load_fault = 2'h0;
wire i_hdr_valid, i_rx_valid, i_tx_ready, o_tx_valid;
wire [7:0] i_pid, i_rx_byte, o_channel_output, o_tx_byte;
wire [1:0] o_open_load_en;
wire [2:0] o_bus_error_code;
wire [4:0] o_app_fault_info;
integer miscompares = 0, n_tests = 0, cyc = 0, k;
always #2 i_core_clk = ~i_core_clk;
lrcd_decoder dut (.i_core_clk(i_core_clk), .i_reset(i_reset),
	.i_nad_sel(i_nad_sel), .i_position_select(i_position_select),
	.i_hdr_valid(i_hdr_valid), .i_pid(i_pid), .i_rx_valid(i_rx_valid),
	.i_rx_byte(i_rx_byte), .i_err_data(i_err_data),
	.i_err_framing(i_err_framing), .i_err_parity(i_err_parity),
	.i_tx_ready(i_tx_ready), .i_overcurrent(i_overcurrent),
	.i_thermal_shutdown(i_thermal_shutdown),
	.i_global_tsd(i_global_tsd), .i_open_load_fault(i_open_load_fault),
	.o_channel_output(o_channel_output), .o_open_load_en(o_open_load_en),
	.o_tx_valid(o_tx_valid), .o_tx_byte(o_tx_byte),
	.o_bus_error_code(o_bus_error_code),
	.o_app_fault_info(o_app_fault_info));
lrcd_lin_master u_lin (.i_clk(i_core_clk), .i_tx_valid(o_tx_valid),
	.i_tx_byte(o_tx_byte), .o_hdr_valid(i_hdr_valid), .o_pid(i_pid),
	.o_rx_valid(i_rx_valid), .o_rx_byte(i_rx_byte), .o_tx_ready(i_tx_ready));
////////////////////////////////////////////////////////////////////////
task tally_and_finish;
	begin
		$display("tests %0d miscompares %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	end
endtask
task stat(input [7:0] b1, input [7:0] s1, input [7:0] s2);
	reg [71:0] r;
	reg [7:0] p, c;
	begin
		p = u_lin.pid({i_nad_sel, 3'h0} + 6'h2 + {4'h0, i_position_select});
		c = u_lin.add(u_lin.add(u_lin.add(p, b1), s1), s2);
		u_lin.status(p, r);
		`CHK("status", {b1, s1, s2, 40'h0, ~c}, r)
	end
endtask
task ctrl(input [63:0] d, input bad);
	begin
		u_lin.send(u_lin.pid({i_nad_sel, 3'h1}), d, bad);
		repeat (3) @(posedge i_core_clk);
		#1;
	end
endtask
always @(posedge i_core_clk) begin
	cyc = cyc + 1;
	if (cyc == 5000) begin
		miscompares++;
		tally_and_finish;
	end
end
////////////////////////////////////////////////////////////////////////
initial begin
	repeat (2) @(posedge i_core_clk);
	#1 i_reset = 0;
	repeat (3) @(posedge i_core_clk);
	stat(8'h20, 8'h55, 8'h55);
	for (k = 0; k < 7; k++) begin
		i_nad_sel = k[2:0];
		repeat (4) @(posedge i_core_clk);
		stat(8'h00, 8'h55, 8'h55);
	end
	ctrl({16'hAAAA, 16'h862E, 32'hAAAAAAAA}, 1'b0);
	`CHK("outputs", 8'h59, o_channel_output)
	`CHK("ol enable", 2'h2, o_open_load_en)
	stat(8'h00, 8'h96, 8'h66);
	ctrl(64'hAAAAAAAAAAAAAAAA, 1'b1);
	`CHK("bad frame", 8'h59, o_channel_output)
	`CHK("csum code", 3'h5, o_bus_error_code)
	stat(8'hA0, 8'h96, 8'h66);
	for (k = 1; k < 4; k++) begin
		{i_err_parity, i_err_framing, i_err_data} = (3'h1 << k) - 3'h1;
		@(posedge i_core_clk) #1;
		{i_err_parity, i_err_framing, i_err_data} = 3'h0;
		stat({k == 1 ? 3'h4 : k == 2 ? 3'h6 : 3'h7, 5'h00}, 8'h96, 8'h66);
	end
	i_overcurrent = 8'h08;
	repeat (6) @(posedge i_core_clk);
	#1 `CHK("oc off", 8'h51, o_channel_output)
	`CHK("oc fault", 5'h08, o_app_fault_info)
	stat(8'h08, 8'hD6, 8'h66);
	i_overcurrent = 8'h00;
	ctrl({16'h0, 16'h4000, 32'h0}, 1'b0);
	`CHK("fault cleared", 5'h00, o_app_fault_info)
	i_global_tsd = 1'b1;
	repeat (6) @(posedge i_core_clk);
	#1 `CHK("global off", 8'h00, o_channel_output)
	`CHK("global fault", 5'h04, o_app_fault_info)
	stat(8'h04, 8'h55, 8'h55);
	i_global_tsd = 1'b0;
	ctrl(64'h5555555555555555, 1'b0);
	`CHK("global cleared", 5'h00, o_app_fault_info)
	i_open_load_fault = 2'h3;
	repeat (6) @(posedge i_core_clk);
	#1 `CHK("ol enable off", 2'h3, o_open_load_en)
	stat(8'h00, 8'h15, 8'h15);
	ctrl({16'h0, 16'h0080, 32'h0}, 1'b0);
	`CHK("ch8 on", 8'h80, o_channel_output)
	i_thermal_shutdown = 2'h2;
	repeat (6) @(posedge i_core_clk);
	#1 `CHK("local thermal", 8'h00, o_channel_output)
	`CHK("ch8 fault", 5'h08, o_app_fault_info)
	stat(8'h08, 8'h15, 8'hD5);
	tally_and_finish;
end
endmodule // lrcd_decoder_tb
bind lrcd_decoder lrcd_decoder_props u_props (.i_core_clk(i_core_clk),
	.i_reset(i_reset), .i_hdr_valid(i_hdr_valid), .i_err_data(i_err_data),
	.i_err_framing(i_err_framing), .i_err_parity(i_err_parity),
	.i_tx_ready(i_tx_ready), .i_global_tsd(i_global_tsd),
	.o_channel_output(o_channel_output), .o_open_load_en(o_open_load_en),
	.o_tx_valid(o_tx_valid), .o_tx_byte(o_tx_byte),
	.o_bus_error_code(o_bus_error_code),
	.o_app_fault_info(o_app_fault_info));
